// ==== verilog/nand_host_pkg.sv ====
// nand_host_pkg: constants shared by the host-side nand command controller
// assumes a 250 MHz system clock; all pin timing is derived from it
package nand_host_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int T_WP_NS = 35;          // write strobe low width
	localparam int T_WH_NS = 15;          // write strobe high hold
	localparam int T_RP_NS = 25;          // read strobe low width
	localparam int T_REH_NS = 25;         // read strobe high hold (cycle 50 ns)
	localparam int T_WHR_NS = 60;         // write high to read low
	localparam int T_CEH_NS = 100;        // chip select break hold
	localparam int T_RST_US = 5;          // reset busy bound
	localparam int T_DBSY_US = 10;        // dummy busy bound
	localparam int T_WB_NS = 100;         // write high to busy
	function automatic int ns_cycles(input int ns);
		return (ns * CLK_MHZ + 999) / 1000;
	endfunction
	localparam int WP_CYC = ns_cycles(T_WP_NS);
	localparam int WH_CYC = ns_cycles(T_WH_NS);
	localparam int RP_CYC = ns_cycles(T_RP_NS);
	localparam int REH_CYC = ns_cycles(T_REH_NS);
	localparam int WHR_CYC = ns_cycles(T_WHR_NS);
	localparam int CEH_CYC = ns_cycles(T_CEH_NS) + 1;   // strictly longer than the hold
	localparam int WB_CYC = ns_cycles(T_WB_NS);
	localparam int RST_CYC = T_RST_US * CLK_MHZ;
	localparam int DBSY_CYC = T_DBSY_US * CLK_MHZ;
	localparam int TW = 8;
	// ----------------------------------------
	// commands and layout
	// ----------------------------------------
	localparam logic [7:0] CMD_PTR_A = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] CMD_PROG = 8'h80;
	localparam logic [7:0] CMD_ERASE = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_PLANE_GO = 8'h11;
	localparam logic [15:0] ERASED = 16'hffff;
	localparam int BAD_COL_X8 = 517;
	localparam int BAD_COL_X16_A = 256;
	localparam int BAD_COL_X16_B = 261;
	localparam int ADDR_CYCLES = 3;
	localparam int MAIN_PROG_MAX = 1;
	localparam int SPARE_PROG_MAX = 2;
	localparam int DW = 16;
	localparam int FIFO_DEPTH = 8;
	// host request kinds
	localparam logic [1:0] OP_CMD = 2'h0;
	localparam logic [1:0] OP_ADDR = 2'h1;
	localparam logic [1:0] OP_WDATA = 2'h2;
	localparam logic [1:0] OP_RDATA = 2'h3;
endpackage

// ==== verilog/stream_if.sv ====
// stream_if: valid/ready word channel between the controller and its fifo
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int W = 16);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== verilog/word_fifo.sv ====
// word_fifo: small synchronous fifo with registered read data
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	stream_if.snk wr,
	stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	logic [W-1:0] out;
	logic out_valid;
	// ----------------------------------------
	// flags
	// ----------------------------------------
	wire push = wr.valid && wr.ready;
	wire load = (count != '0) && (!out_valid || rd.ready);
	wire pop_out = out_valid && rd.ready;
	assign wr.ready = (count != (AW+1)'(DEPTH));
	assign rd.valid = out_valid;
	assign rd.data = out;
	// storage and output register
	always_ff @(posedge sys_clk_i) begin
		if (push)
			mem[wptr] <= wr.data;
		if (load)
			out <= mem[rptr];
	end
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wptr <= wptr + 1'b1;
			if (load)
				rptr <= rptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(load);
			if (load)
				out_valid <= 1'b1;
			else if (pop_out)
				out_valid <= 1'b0;
		end
	end
endmodule // word_fifo
`default_nettype wire

// ==== verilog/nand_host_ctrl.sv ====
// nand_host_ctrl: host controller that strobes commands, addresses and data into a nand flash
// assumes the flash pins are sampled on sys_clk_i; read data is pushed through an 8-word fifo
// How it works
// - a sequential read is ended by holding chip select high for longer than 100 ns.
// - main area of a page is programmed once and spare area at most twice between erases.
// - the caller remaps around bad blocks using the bad flag this controller reports.
// - the bad table is built from factory marks first and an erase is refused while the bad flag from the last check is set.
// - on x16 parts the upper eight lines are driven to zero on command and address cycles.
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// request port
	input wire logic req_valid_i,
	input wire logic [1:0] req_op_i,
	input wire logic [15:0] req_data_i,
	input wire logic req_last_i,
	input wire logic req_plane_i,
	input wire logic req_spare_i,
	input wire logic req_bad_check_i,
	input wire logic req_block_zero_i,
	input wire logic wide_i,
	input wire logic wp_allow_i,
	output logic req_ready_o,
	output logic refused_o,
	output logic bad_mark_o,
	output logic rd_valid_o,
	output logic [15:0] rd_data_o,
	input wire logic rd_ready_i,
	// flash pins
	output logic ce_n_o,
	output logic cle_o,
	output logic ale_o,
	output logic we_n_o,
	output logic read_strobe_n_o,
	output logic wp_n_o,
	output logic [15:0] io_o,
	output logic io_oe_o,
	input wire logic [15:0] io_i,
	input wire logic ready_busy_i
);
	typedef enum {S_IDLE, S_WLOW, S_WHIGH, S_WAITB, S_BUSY, S_RWAIT, S_RLOW, S_RHIGH, S_CEH} state_t;
	state_t state;
	logic [12:0] cnt;
	logic [1:0] op;
	logic last;
	logic plane;
	logic reset_cmd;
	logic [1:0] spare_progs;
	logic main_prog;
	logic prog_open;
	logic wr_spare;
	stream_if #(.W(nand_host_pkg::DW)) fin ();
	stream_if #(.W(nand_host_pkg::DW)) fout ();
	// ----------------------------------------
	// request decode
	// ----------------------------------------
	wire is_cmd = req_op_i == nand_host_pkg::OP_CMD;
	wire is_addr = req_op_i == nand_host_pkg::OP_ADDR;
	wire is_write = req_op_i != nand_host_pkg::OP_RDATA;
	wire is_prot = is_cmd && (req_data_i[7:0] == nand_host_pkg::CMD_PROG
		|| req_data_i[7:0] == nand_host_pkg::CMD_ERASE);
	wire wp_block = is_prot && !wp_allow_i;
	wire over_main = is_cmd && req_data_i[7:0] == nand_host_pkg::CMD_PROG && !req_spare_i
		&& main_prog;
	wire over_spare = is_cmd && req_data_i[7:0] == nand_host_pkg::CMD_PROG && req_spare_i
		&& spare_progs == 2'(nand_host_pkg::SPARE_PROG_MAX);
	wire erase_marked = is_cmd && req_data_i[7:0] == nand_host_pkg::CMD_ERASE && bad_mark_o;
	wire refuse = wp_block || over_main || over_spare || erase_marked;
	// an answered request still stands at the answer edge, so it is not taken again there
	wire take = state == S_IDLE && req_valid_i && !req_ready_o && (is_write || fin.ready);
	wire [15:0] drive_word = (is_cmd || is_addr) ? {8'h00, req_data_i[7:0]} : req_data_i;
	wire erased = wide_i ? (io_i == nand_host_pkg::ERASED) : (io_i[7:0] == nand_host_pkg::ERASED[7:0]);
	wire cnt_done = cnt == '0;
	assign fin.valid = state == S_RLOW && cnt_done;
	assign fin.data = wide_i ? io_i : {8'h00, io_i[7:0]};
	assign fout.ready = rd_ready_i || !rd_valid_o;
	word_fifo #(.W(nand_host_pkg::DW), .DEPTH(nand_host_pkg::FIFO_DEPTH)) rd_fifo (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.wr(fin),
		.rd(fout)
	);
	// ----------------------------------------
	// pin sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state <= S_IDLE;
			cnt <= '0;
			op <= nand_host_pkg::OP_CMD;
			last <= 1'b0;
			plane <= 1'b0;
			reset_cmd <= 1'b0;
			ce_n_o <= 1'b1;
			cle_o <= 1'b0;
			ale_o <= 1'b0;
			we_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			wp_n_o <= 1'b0;
			io_o <= '0;
			io_oe_o <= 1'b0;
			req_ready_o <= 1'b0;
			refused_o <= 1'b0;
		end else begin
			refused_o <= 1'b0;
			req_ready_o <= 1'b0;
			wp_n_o <= wp_allow_i;
			if (!cnt_done)
				cnt <= cnt - 1'b1;
			unique case (state)
				S_IDLE: begin
					if (take && refuse) begin
						refused_o <= 1'b1;
						req_ready_o <= 1'b1;
					end else if (take) begin
						op <= req_op_i;
						last <= req_last_i;
						plane <= req_plane_i;
						reset_cmd <= is_cmd && req_data_i[7:0] == nand_host_pkg::CMD_RESET;
						ce_n_o <= 1'b0;
						cle_o <= is_cmd;
						ale_o <= is_addr;
						if (is_write) begin
							io_o <= wide_i ? drive_word : {8'h00, drive_word[7:0]};
							io_oe_o <= 1'b1;
							we_n_o <= 1'b0;
							cnt <= 13'(nand_host_pkg::WP_CYC - 1);
							state <= S_WLOW;
						end else begin
							io_oe_o <= 1'b0;
							cnt <= 13'(nand_host_pkg::WHR_CYC - 1);
							state <= S_RWAIT;
						end
					end
				end
				S_WLOW: if (cnt_done) begin
					we_n_o <= 1'b1;                                    // data latched on the rising strobe
					cnt <= 13'(nand_host_pkg::WH_CYC - 1);
					state <= S_WHIGH;
				end
				S_WHIGH: if (cnt_done) begin
					cle_o <= 1'b0;
					ale_o <= 1'b0;
					io_oe_o <= 1'b0;
					if (op == nand_host_pkg::OP_CMD && (reset_cmd || last || plane)) begin
						cnt <= 13'(nand_host_pkg::WB_CYC - 1);
						state <= S_WAITB;
					end else begin
						req_ready_o <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_WAITB: if (cnt_done) begin
					cnt <= reset_cmd ? 13'(nand_host_pkg::RST_CYC) : 13'(nand_host_pkg::DBSY_CYC);
					state <= S_BUSY;
				end
				S_BUSY: if (ready_busy_i || cnt_done) begin            // timeout bounds a stuck busy line
					ce_n_o <= 1'b1;
					req_ready_o <= 1'b1;                               // answer only once busy is over or its timeout runs out
					state <= S_IDLE;
				end
				S_RWAIT: if (cnt_done && ready_busy_i && fin.ready) begin
					read_strobe_n_o <= 1'b0;
					cnt <= 13'(nand_host_pkg::RP_CYC - 1);
					state <= S_RLOW;
				end
				S_RLOW: if (cnt_done) begin                              // word is pushed this cycle
					read_strobe_n_o <= 1'b1;
					cnt <= 13'(nand_host_pkg::REH_CYC - 1);
					state <= S_RHIGH;
				end
				S_RHIGH: if (cnt_done) begin
					req_ready_o <= 1'b1;
					if (last) begin
						ce_n_o <= 1'b1;
						cnt <= 13'(nand_host_pkg::CEH_CYC - 1);
						state <= S_CEH;
					end else
						state <= S_IDLE;
				end
				S_CEH: if (cnt_done)
					state <= S_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// partial program bookkeeping and bad mark check
	// ----------------------------------------
	wire prog_go = state == S_WHIGH && cnt_done && op == nand_host_pkg::OP_CMD && last;
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			main_prog <= 1'b0;
			spare_progs <= '0;
			prog_open <= 1'b0;
			wr_spare <= 1'b0;
			bad_mark_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= '0;
		end else begin
			if (take && !refuse && is_cmd && req_data_i[7:0] == nand_host_pkg::CMD_ERASE) begin
				main_prog <= 1'b0;
				spare_progs <= '0;
			end else if (take && !refuse && is_cmd && req_data_i[7:0] == nand_host_pkg::CMD_PROG) begin
				prog_open <= 1'b1;
				wr_spare <= req_spare_i;
			end else if (prog_go && prog_open) begin
				prog_open <= 1'b0;
				if (wr_spare)
					spare_progs <= spare_progs + 1'b1;
				else
					main_prog <= 1'b1;
			end
			if (take && req_op_i == nand_host_pkg::OP_RDATA && req_bad_check_i)
				bad_mark_o <= 1'b0;
			else if (fin.valid && req_bad_check_i && !req_block_zero_i && !erased)
				bad_mark_o <= 1'b1;
			if (fout.ready) begin
				rd_valid_o <= fout.valid;
				rd_data_o <= fout.data;
			end
		end
	end
endmodule // nand_host_ctrl
`default_nettype wire

// ==== tb/nand_host_checker.sv ====
// nand_host_checker: pin and handshake properties of the nand host controller
// assumes it is bound to nand_host_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module nand_host_checker (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic req_valid_i,
	input wire logic [1:0] req_op_i,
	input wire logic [15:0] req_data_i,
	input wire logic wp_allow_i,
	input wire logic req_ready_o,
	input wire logic refused_o,
	input wire logic cle_o,
	input wire logic ale_o,
	input wire logic we_n_o,
	input wire logic read_strobe_n_o,
	input wire logic wp_n_o,
	input wire logic [15:0] io_o,
	input wire logic io_oe_o
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	a_refused_with_ready: assert property (refused_o |-> req_ready_o) else $error("refusal without answer");
	a_wp_refuse_prog: assert property (req_valid_i && req_ready_o && req_op_i == nand_host_pkg::OP_CMD
		&& req_data_i[7:0] == nand_host_pkg::CMD_PROG && !wp_allow_i |-> refused_o) else $error("prog not refused");
	a_wp_pin_follows: assert property (!wp_allow_i ##1 !wp_allow_i |-> !wp_n_o) else $error("wp pin high");
	a_latch_exclusive: assert property (cle_o |-> !ale_o) else $error("cle and ale together");
	a_upper_byte_zero: assert property (io_oe_o && (cle_o || ale_o) |-> io_o[15:8] == 8'h00) else $error("upper io set");
	a_we_low_width: assert property ($fell(we_n_o) |-> !we_n_o [*8]) else $error("write strobe too short");
	a_strobe_exclusive: assert property (we_n_o || read_strobe_n_o) else $error("both strobes low");
	a_read_no_drive: assert property (!read_strobe_n_o |-> !io_oe_o) else $error("io driven while reading");
	c_refused: cover property (refused_o);
	c_read: cover property (!read_strobe_n_o);
	c_cmd: cover property (cle_o && !we_n_o);
endmodule // nand_host_checker
bind nand_host_ctrl nand_host_checker i_chk (.sys_clk_i, .nrst_i, .req_valid_i, .req_op_i, .req_data_i, .wp_allow_i,
	.req_ready_o, .refused_o, .cle_o, .ale_o, .we_n_o, .read_strobe_n_o, .wp_n_o, .io_o, .io_oe_o);
`default_nettype wire

// ==== tb/nand_flash_model.sv ====
// nand_flash_model: behavioural flash device answering the controller's pins
// assumes the bench sets busy length and whether the block carries a bad mark
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model (
	input wire logic sys_clk_i,
	input wire logic ce_n_i,
	input wire logic cle_i,
	input wire logic ale_i,
	input wire logic we_n_i,
	input wire logic rs_n_i,
	input wire logic wp_n_i,
	input wire logic [15:0] io_i,
	output logic [15:0] io_o,
	output logic rb_o,
	input wire logic [31:0] busy_cyc_i,
	input wire logic bad_i
);
	// ----------------------------------------
	// latches and busy
	// ----------------------------------------
	logic [15:0] cmd = 16'h0000;
	logic [15:0] last = 16'h0000;
	int n_addr = 0;
	int busy = 0;
	// command and address taken on the rising write strobe
	always @(posedge we_n_i) begin
		if (!ce_n_i && cle_i && !ale_i) begin
			cmd = io_i;
			n_addr = 0;
			if (io_i[7:0] == nand_host_pkg::CMD_RESET || io_i[7:0] == nand_host_pkg::CMD_PLANE_GO) busy <= busy_cyc_i;
			if (io_i[7:0] == nand_host_pkg::CMD_PROG_GO && wp_n_i) busy <= busy_cyc_i;
		end
		if (!ce_n_i && ale_i && !cle_i) n_addr++;
	end
	// non-blocking so the controller samples the ready line without a race
	always @(posedge sys_clk_i) if (busy > 0) busy <= busy - 1;
	assign rb_o = (busy == 0);
	// erased word unless the block is marked; same timing either way
	always @(negedge rs_n_i) if (!ce_n_i) last = bad_i ? 16'h00ff : nand_host_pkg::ERASED;
	assign io_o = (!rs_n_i && !ce_n_i) ? last : ~last; // released bus shows no stale value
endmodule // nand_flash_model
`default_nettype wire

// ==== tb/tb_nand_host_ctrl.sv ====
// tb_nand_host_ctrl: directed scenarios for the nand host controller
// assumes the flash model on the pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_nand_host_ctrl;
	// ----------------------------------------
	// bench signals and instances
	// ----------------------------------------
	logic sys_clk_i = 0, nrst_i = 0, req_valid_i = 0, req_last_i = 0, req_plane_i = 0, req_spare_i = 0, bad = 0;
	logic req_bad_check_i = 0, req_block_zero_i = 0, wide_i = 1, wp_allow_i = 0, rd_ready_i = 0, refd = 0;
	logic [1:0] req_op_i = 2'h0;
	logic [15:0] req_data_i = 16'h0000, exp_word = 16'hffff, io_i, io_o, rd_data_o;
	logic req_ready_o, refused_o, bad_mark_o, rd_valid_o, ce_n_o, cle_o, ale_o, we_n_o, read_strobe_n_o, wp_n_o;
	logic io_oe_o, ready_busy_i;
	int err_count = 0, total_checks = 0, busy_cyc = 10, lat = 0, pops = 0, hi = 0, brk = 0;
	nand_host_ctrl i_dut (.*);
	nand_flash_model i_flash (.sys_clk_i(sys_clk_i), .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
		.rs_n_i(read_strobe_n_o), .wp_n_i(wp_n_o), .io_i(io_o), .io_o(io_i), .rb_o(ready_busy_i),
		.busy_cyc_i(busy_cyc), .bad_i(bad));
	initial forever #2 sys_clk_i = ~sys_clk_i;
	task automatic report_and_stop;
		if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: %s %h", $time, msg, got);
		end
	endtask
	// one request held until its answer
	task automatic do_req(input logic [1:0] op, input logic [15:0] d);
		@(posedge sys_clk_i);
		req_valid_i <= 1'b1;
		req_op_i <= op;
		req_data_i <= d;
		lat = 0;
		do begin
			@(posedge sys_clk_i);
			lat++;
		end while (req_ready_o !== 1'b1 && lat < 5000);
		refd = refused_o;
		req_valid_i <= 1'b0;
		chk_bit(lat < 5000, 1'b1, "no answer");
	endtask
	// popped words and chip select break length
	always @(posedge sys_clk_i) begin
		if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
			pops++;
			chk_word(rd_data_o, exp_word, "read word");
		end
		if (ce_n_o === 1'b1) hi++;
		else begin
			if (hi > 0) brk = hi;
			hi = 0;
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_cmd_addr;
		do_req(nand_host_pkg::OP_CMD, {8'hc3, nand_host_pkg::CMD_PTR_A});
		chk_word(i_flash.cmd, 16'h0000, "command cycle");
		repeat (3) do_req(nand_host_pkg::OP_ADDR, 16'h5a12);
		chk_bit(i_flash.n_addr == 3, 1'b1, "address cycles");
	endtask
	task automatic t_reset_busy;
		busy_cyc = 100;
		do_req(nand_host_pkg::OP_CMD, {8'h00, nand_host_pkg::CMD_RESET});
		chk_bit(lat > 100, 1'b1, "answer before ready");
		busy_cyc = 1500;
		do_req(nand_host_pkg::OP_CMD, {8'h00, nand_host_pkg::CMD_RESET});
		chk_bit(lat < 1400, 1'b1, "reset wait not bounded");
		repeat (300) @(posedge sys_clk_i);
	endtask
	task automatic t_prog_limits;
		do_req(nand_host_pkg::OP_CMD, {8'h00, nand_host_pkg::CMD_PROG});
		chk_bit(refd, 1'b1, "prog under wp");
		chk_word(i_flash.cmd, 16'h00ff, "pins moved on refusal");
		wp_allow_i <= 1'b1;
		busy_cyc = 40;
		for (int i = 0; i < 6; i++) begin
			req_spare_i <= (i > 2);
			do_req(nand_host_pkg::OP_CMD, {8'h00, (i == 0) ? nand_host_pkg::CMD_ERASE : nand_host_pkg::CMD_PROG});
			chk_bit(refd, i == 2 || i == 5, "program count");
			if (i != 0 && !refd) begin
				// a program only counts once it is confirmed
				req_last_i <= 1'b1;
				do_req(nand_host_pkg::OP_CMD, {8'h00, nand_host_pkg::CMD_PROG_GO});
				chk_bit(refd, 1'b0, "confirm refused");
				req_last_i <= 1'b0;
			end
		end
		chk_bit(wp_n_o, 1'b1, "wp pin");
		req_spare_i <= 1'b0;
		busy_cyc = 250;
		req_plane_i <= 1'b1;
		do_req(nand_host_pkg::OP_CMD, {8'h00, nand_host_pkg::CMD_PLANE_GO});
		chk_bit(lat > 250, 1'b1, "dummy busy skipped");
		req_plane_i <= 1'b0;
	endtask
	task automatic t_reads;
		rd_ready_i <= 1'b1;
		req_bad_check_i <= 1'b1;
		req_last_i <= 1'b1;
		do_req(nand_host_pkg::OP_RDATA, 16'h0000);
		chk_bit(bad_mark_o, 1'b0, "erased word flagged");
		bad <= 1'b1;
		exp_word <= 16'h00ff;
		req_block_zero_i <= 1'b1;
		do_req(nand_host_pkg::OP_RDATA, 16'h0000);
		chk_bit(bad_mark_o, 1'b0, "block zero flagged");
		req_block_zero_i <= 1'b0;
		req_last_i <= 1'b0;
		rd_ready_i <= 1'b0;
		do_req(nand_host_pkg::OP_RDATA, 16'h0000);
		chk_bit(brk > 25, 1'b1, "chip select break");
		repeat (9) do_req(nand_host_pkg::OP_RDATA, 16'h0000);
		chk_bit(bad_mark_o, 1'b1, "mark missed");
		fork
			begin
				repeat (200) @(posedge sys_clk_i);
				rd_ready_i <= 1'b1;
			end
			do_req(nand_host_pkg::OP_RDATA, 16'h0000);
		join
		chk_bit(lat > 200, 1'b1, "taken while fifo full");
		repeat (20) @(posedge sys_clk_i);
		chk_bit(pops == 13, 1'b1, "words drained");
		do_req(nand_host_pkg::OP_CMD, {8'h00, nand_host_pkg::CMD_ERASE});
		chk_bit(refd, 1'b1, "marked block erased");
	endtask
	initial begin
		#80000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		chk_bit(ce_n_o & we_n_o & ~wp_n_o & ~io_oe_o, 1'b1, "reset pin levels");
		t_cmd_addr();
		t_reset_busy();
		t_prog_limits();
		t_reads();
		report_and_stop();
	end
endmodule // tb_nand_host_ctrl
`default_nettype wire
